// [rtl/sac_pkg.sv]
// Package of shared constants and types for the converter acquisition control.
package sac_pkg;

  // ******************************************************************
  // Control byte field positions
  // ******************************************************************
  localparam int PWR_HI_POS = 7;
  localparam int PWR_LO_POS = 6;
  localparam int ACQ_POS    = 5;
  localparam int CFG_POS    = 4;
  localparam int POL_POS    = 3;
  localparam int CH_MSB     = 2;

  // ******************************************************************
  // Power and clock mode codes, reset values and timing counts
  // ******************************************************************
  localparam logic [1:0] PWR_FULL_DOWN = 2'h0;
  localparam logic [1:0] PWR_STANDBY   = 2'h1;
  localparam logic [1:0] PWR_INT_CLK   = 2'h2;
  localparam logic [1:0] PWR_EXT_CLK   = 2'h3;
  localparam logic [7:0] CTRL_RST      = 8'hC0;
  localparam int         ACQ_INT_FALLS = 4;
  localparam int         CONV_CYCLES   = 13;
  localparam int         RES_BITS      = 12;
  localparam int         LO_BITS       = 8;
  // Internal oscillator period in ns; timing of that oscillator is modelled.
  localparam int         OSC_PERIOD_NS = 280;
  localparam int         CLK_PERIOD_NS = 10;
  localparam int         OSC_HALF_CYC  = (OSC_PERIOD_NS / 2) / CLK_PERIOD_NS;

  // ******************************************************************
  // Converter sequencing states
  // ******************************************************************
  typedef enum logic [1:0] {
    SAC_IDLE  = 2'b00,
    SAC_TRACK = 2'b01,
    SAC_CONV  = 2'b11,
    SAC_DONE  = 2'b10
  } sac_state_t;

endpackage : sac_pkg

// [rtl/sac_if.sv]
// Interface carrying the byte-wide parallel port between host and converter.
`timescale 1ns/100ps
`default_nettype none
interface sac_if;
  logic       cs_n;
  logic       wr_n;
  logic       rd_n;
  logic       high_byte_select;
  logic       ext_clk;
  logic [7:0] host_d;
  logic       host_d_oe;
  logic [7:0] dev_d;
  logic       dev_d_oe;
  logic       done_n;
  logic       done_oe;

  modport dev  (input cs_n, wr_n, rd_n, high_byte_select, ext_clk, host_d, host_d_oe,
                output dev_d, dev_d_oe, done_n, done_oe);
  modport host (output cs_n, wr_n, rd_n, high_byte_select, ext_clk, host_d, host_d_oe,
                input dev_d, dev_d_oe, done_n, done_oe);
endinterface : sac_if
`default_nettype wire

// [rtl/sac_edge.sv]
// Edge detector for a synchronous strobe input.
`timescale 1ns/100ps
`default_nettype none
module sac_edge
(
  // Clock and reset.
  input  wire logic mclk_i,
  input  wire logic nrst_i,
  // Sampled level and its edges.
  input  wire logic lvl_i,
  output logic      rise_o,
  output logic      fall_o
);

  logic lvl_ff;

  // Previous level; resets high because every strobe here idles high.
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      lvl_ff <= 1'b1;
    else
      lvl_ff <= lvl_i;
  end

  // Edges are combinational so events land in the cycle the level changes.
  assign rise_o = lvl_i & ~lvl_ff;
  assign fall_o = ~lvl_i & lvl_ff;

endmodule : sac_edge
`default_nettype wire

// [rtl/sac_dev.sv]
// Converter end: control byte latch, track/hold sequencing and result port.
// Functional notes
// - Write strobe rise while selected starts tracking.
// - External mode: next write rise enters hold.
// - Internal mode: hold on fourth clock fall.
// - Conversion takes exactly thirteen conversion-clock cycles.
// - Write during conversion aborts, restarts acquisition.
// - Mode bit clear: timed acquisition, auto conversion.
// - Mode bit set: acquisition lasts until next write.
// - Second write, mode bit clear, starts conversion.
// - Host keeps channel bits same across both writes.
// - Host changes only the mode bit on second write.
// - Completion flag goes low when result ready.
// - Flag releases on first read or new write.
// - Single-ended: channel positive, ground-return negative.
// - Pseudo-differential: both nodes from channel pair.
// - Host write selects channel and polarity to start.
// - Twelve-bit result split into eight plus four.
// - Control byte: power, mode, config, polarity, channel.
// - High byte select picks low or high; high is zero-filled unipolar, sign-filled bipolar.
// - Deselected: ignore strobes, bus and flag released.
// - Straight binary unipolar, two's complement bipolar.
`timescale 1ns/100ps
`default_nettype none
module sac_dev
#(
  parameter int NUM_CH = 8
)
(
  // Clock and reset.
  input  wire logic                mclk_i,
  input  wire logic                nrst_i,
  // Parallel port toward the host.
  sac_if.dev                       bus,
  // Analog front end: comparator decision and multiplexer settings.
  input  wire logic                cmp_i,
  output logic                     track_o,
  output logic [2:0]               pos_node_o,
  output logic [2:0]               neg_node_o,
  output logic                     neg_is_return_o,
  output logic [sac_pkg::RES_BITS-1:0] dac_code_o,
  output logic [1:0]               power_mode_o
);
  import sac_pkg::*;

  // ******************************************************************
  // Strobe qualification
  // ******************************************************************
  logic wr_rise, rd_fall, eclk_fall;
  logic sel;
  logic osc_ff;
  logic [7:0] osc_cnt_ff;
  logic oclk_fall;

  // Strobes count only while the chip is selected.
  assign sel = ~bus.cs_n;

  sac_edge u_wr (.mclk_i(mclk_i), .nrst_i(nrst_i), .lvl_i(bus.wr_n | ~sel),
                 .rise_o(wr_rise), .fall_o());
  sac_edge u_rd (.mclk_i(mclk_i), .nrst_i(nrst_i), .lvl_i(bus.rd_n | ~sel),
                 .rise_o(), .fall_o(rd_fall));
  sac_edge u_ec (.mclk_i(mclk_i), .nrst_i(nrst_i), .lvl_i(bus.ext_clk | ~sel),
                 .rise_o(), .fall_o(eclk_fall));
  sac_edge u_oc (.mclk_i(mclk_i), .nrst_i(nrst_i), .lvl_i(osc_ff),
                 .rise_o(), .fall_o(oclk_fall));

  // Internal oscillator, derived from the system clock by division.
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      osc_cnt_ff <= 8'h00;
      osc_ff     <= 1'b1;
    end
    else if (osc_cnt_ff == 8'(OSC_HALF_CYC - 1))
    begin
      osc_cnt_ff <= 8'h00;
      osc_ff     <= ~osc_ff;
    end
    else
      osc_cnt_ff <= osc_cnt_ff + 8'h01;
  end

  // ******************************************************************
  // Control byte and clock selection
  // ******************************************************************
  logic [7:0] ctrl_ff;
  logic       ext_clk_mode_ff;
  logic       tick;
  logic       acq_ext;

  // Latch the control byte; power-down codes keep the last clock mode.
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ctrl_ff         <= CTRL_RST;
      ext_clk_mode_ff <= 1'b1;
    end
    else if (wr_rise)
    begin
      ctrl_ff <= bus.host_d;
      if (bus.host_d[PWR_HI_POS])
        ext_clk_mode_ff <= bus.host_d[PWR_LO_POS];
    end
  end

  assign tick    = ext_clk_mode_ff ? eclk_fall : oclk_fall;
  assign acq_ext = ctrl_ff[ACQ_POS];
  assign power_mode_o = ctrl_ff[PWR_HI_POS:PWR_LO_POS];

  // Multiplexer routing from the latched configuration.
  always_comb
  begin
    if (ctrl_ff[CFG_POS])
    begin
      pos_node_o      = ctrl_ff[CH_MSB:0];
      neg_node_o      = 3'h0;
      neg_is_return_o = 1'b1;
    end
    else
    begin
      pos_node_o      = {ctrl_ff[CH_MSB:1], ctrl_ff[0]};
      neg_node_o      = {ctrl_ff[CH_MSB:1], ~ctrl_ff[0]};
      neg_is_return_o = 1'b0;
    end
  end

  // ******************************************************************
  // Acquisition and conversion sequencing
  // ******************************************************************
  sac_state_t state_ff;
  logic [3:0] cnt_ff;
  logic [RES_BITS-1:0] sar_ff;
  logic [RES_BITS-1:0] bit_ff;
  logic [RES_BITS-1:0] result_ff;
  logic                result_uni_ff;
  logic                done_n_ff;

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_ff <= SAC_IDLE;
      cnt_ff   <= 4'h0;
      sar_ff   <= '0;
      bit_ff   <= '0;
    end
    else if (wr_rise)
    begin
      cnt_ff <= 4'h0;
      if (state_ff == SAC_TRACK && acq_ext && !bus.host_d[ACQ_POS])
      begin
        state_ff <= SAC_CONV;
        sar_ff   <= '0;
        bit_ff   <= '0;
      end
      else
        state_ff <= SAC_TRACK;
    end
    // Completion lasts one system cycle, so a later read can release the flag.
    else if (state_ff == SAC_DONE)
      state_ff <= SAC_IDLE;
    else if (tick)
    begin
      case (state_ff)
        SAC_TRACK:
        begin
          if (!acq_ext)
          begin
            if (cnt_ff == 4'(ACQ_INT_FALLS - 1))
            begin
              state_ff <= SAC_CONV;
              cnt_ff   <= 4'h0;
              sar_ff   <= '0;
              bit_ff   <= '0;
            end
            else
              cnt_ff <= cnt_ff + 4'h1;
          end
        end
        SAC_CONV:
        begin
          // First cycle swaps the hold capacitor; twelve bit trials follow.
          if (cnt_ff == 4'h0)
          begin
            bit_ff <= {1'b1, {(RES_BITS-1){1'b0}}};
            sar_ff <= {1'b1, {(RES_BITS-1){1'b0}}};
          end
          else
          begin
            if (!cmp_i)
              sar_ff <= (sar_ff & ~bit_ff) | (bit_ff >> 1);
            else
              sar_ff <= sar_ff | (bit_ff >> 1);
            bit_ff <= bit_ff >> 1;
          end
          if (cnt_ff == 4'(CONV_CYCLES - 1))
            state_ff <= SAC_DONE;
          else
            cnt_ff <= cnt_ff + 4'h1;
        end
        SAC_DONE:
          state_ff <= SAC_IDLE;
        default:
          state_ff <= state_ff;
      endcase
    end
  end

  assign track_o    = (state_ff == SAC_TRACK);
  assign dac_code_o = sar_ff;

  // Result register updates only at completion, so bytes read in any order.
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      result_ff     <= '0;
      result_uni_ff <= 1'b1;
    end
    else if (state_ff == SAC_DONE)
    begin
      // Bipolar: flipping the offset-binary MSB gives two's complement.
      result_ff     <= ctrl_ff[POL_POS] ? sar_ff : {~sar_ff[RES_BITS-1], sar_ff[RES_BITS-2:0]};
      result_uni_ff <= ctrl_ff[POL_POS];
    end
  end

  // Completion flag: a new write clears it; a write in the same cycle as completion wins.
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      done_n_ff <= 1'b1;
    else if (state_ff == SAC_DONE && !wr_rise)
      done_n_ff <= 1'b0;
    else if (wr_rise || (rd_fall && !done_n_ff))
      done_n_ff <= 1'b1;
  end

  // ******************************************************************
  // Read data path
  // ******************************************************************
  always_comb
  begin
    if (bus.high_byte_select)
      bus.dev_d = {{4{result_uni_ff ? 1'b0 : result_ff[RES_BITS-1]}},
                   result_ff[RES_BITS-1:LO_BITS]};
    else
      bus.dev_d = result_ff[LO_BITS-1:0];
  end

  assign bus.dev_d_oe = sel & ~bus.rd_n;
  assign bus.done_n   = done_n_ff;
  assign bus.done_oe  = sel;

endmodule : sac_dev
`default_nettype wire

// [rtl/sac_host.sv]
// Host end: drives control-byte writes and two-byte result reads.
`timescale 1ns/100ps
`default_nettype none
module sac_host
#(
  parameter int STROBE_CYC = 4
)
(
  // Clock and reset.
  input  wire logic       mclk_i,
  input  wire logic       nrst_i,
  // Parallel port toward the converter.
  sac_if.host             bus,
  // User command side.
  input  wire logic       wr_req_i,
  input  wire logic [7:0] wr_byte_i,
  input  wire logic       rd_req_i,
  input  wire logic       ext_clk_i,
  output logic            busy_o,
  output logic            rd_valid_o,
  output logic [11:0]     rd_data_o,
  output logic            done_o
);
  import sac_pkg::*;

  typedef enum logic [2:0] {
    SAH_IDLE = 3'b000,
    SAH_WR   = 3'b001,
    SAH_RDL  = 3'b011,
    SAH_RDH  = 3'b010,
    SAH_FIN  = 3'b110
  } sah_state_t;

  sah_state_t  st_ff;
  logic [3:0]  cnt_ff;
  logic [7:0]  dat_ff;
  logic [11:0] rd_ff;
  logic        valid_ff;
  logic        pend_ff;
  logic        last;

  assign last = (cnt_ff == 4'(STROBE_CYC - 1));

  // Strobe sequencer; the caller keeps channel bits stable on a second write.
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_ff    <= SAH_IDLE;
      cnt_ff   <= 4'h0;
      dat_ff   <= 8'h00;
      rd_ff    <= 12'h000;
      valid_ff <= 1'b0;
    end
    else
    begin
      valid_ff <= 1'b0;
      cnt_ff   <= last ? 4'h0 : cnt_ff + 4'h1;
      case (st_ff)
        SAH_IDLE:
        begin
          cnt_ff <= 4'h0;
          if (wr_req_i)
          begin
            st_ff  <= SAH_WR;
            dat_ff <= wr_byte_i;
          end
          else if (rd_req_i)
            st_ff <= SAH_RDL;
        end
        SAH_WR:
          if (last)
            st_ff <= SAH_FIN;
        SAH_RDL:
          if (last)
          begin
            rd_ff[7:0] <= bus.dev_d;
            st_ff      <= SAH_RDH;
          end
        SAH_RDH:
          if (last)
          begin
            rd_ff[11:8] <= bus.dev_d[3:0];
            valid_ff    <= 1'b1;
            st_ff       <= SAH_FIN;
          end
        SAH_FIN:
          if (last)
            st_ff <= SAH_IDLE;
        default:
          st_ff <= SAH_IDLE;
      endcase
    end
  end

  // Stay selected from a write until its result is read.
  // A deselected converter ignores the external clock and hides its flag.
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      pend_ff <= 1'b0;
    else if (st_ff == SAH_IDLE && wr_req_i)
      pend_ff <= 1'b1;
    else if (st_ff == SAH_IDLE && rd_req_i)
      pend_ff <= 1'b0;
  end

  // Strobes toward the converter.
  assign bus.cs_n             = (st_ff == SAH_IDLE) && !pend_ff;
  assign bus.wr_n             = ~(st_ff == SAH_WR);
  assign bus.rd_n             = ~(st_ff == SAH_RDL || st_ff == SAH_RDH);
  assign bus.high_byte_select = (st_ff == SAH_RDH);
  assign bus.host_d           = dat_ff;
  assign bus.host_d_oe        = (st_ff == SAH_WR);
  assign bus.ext_clk          = ext_clk_i;

  assign busy_o     = (st_ff != SAH_IDLE);
  assign rd_valid_o = valid_ff;
  assign rd_data_o  = rd_ff;
  assign done_o     = bus.done_oe & ~bus.done_n;

endmodule : sac_host
`default_nettype wire

// [testbench/sac_chk.sv]
// Checker of the parallel port between the host end and the converter end.
`timescale 1ns/100ps
`default_nettype none
module sac_chk
  import sac_pkg::*;
(
  // Clock and reset.
  input wire logic       mclk_i,
  input wire logic       nrst_i,
  // Port signals.
  input wire logic       cs_n,
  input wire logic       wr_n,
  input wire logic       rd_n,
  input wire logic       high_byte_select,
  input wire logic       ext_clk,
  input wire logic [7:0] host_d,
  input wire logic [7:0] dev_d,
  input wire logic       dev_d_oe,
  input wire logic       done_n,
  input wire logic       done_oe
);
  // ******************************************************************
  // Helper state
  // ******************************************************************
  logic       wr_q_ff;
  logic       rd_q_ff;
  logic       ext_q_ff;
  logic       acq_ff;
  logic       prev_acq_ff;
  logic       uni_ff;
  logic       clk_ext_ff;
  logic [7:0] wbyte_ff;
  logic [4:0] falls_ff;
  logic       wr_rise;
  logic       rd_fall;

  // Strobe edges as the converter sees them while selected.
  assign wr_rise = !cs_n && wr_n && !wr_q_ff;
  assign rd_fall = !cs_n && !rd_n && rd_q_ff;

  // Shadow of the control byte; clock mode is kept over power-down codes.
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wr_q_ff     <= 1'b1;
      rd_q_ff     <= 1'b1;
      wbyte_ff    <= 8'h00;
      acq_ff      <= 1'b0;
      prev_acq_ff <= 1'b0;
      uni_ff      <= 1'b0;
      clk_ext_ff  <= 1'b1;
    end
    else
    begin
      wr_q_ff <= wr_n;
      rd_q_ff <= rd_n;
      if (!cs_n && !wr_n)
        wbyte_ff <= host_d;
      if (wr_rise)
      begin
        prev_acq_ff <= acq_ff;
        acq_ff      <= wbyte_ff[ACQ_POS];
        uni_ff      <= wbyte_ff[POL_POS];
        if (wbyte_ff[PWR_HI_POS])
          clk_ext_ff <= wbyte_ff[PWR_LO_POS];
      end
    end
  end

  // Conversion-clock falls since the last write; saturates so it never wraps.
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ext_q_ff <= 1'b0;
      falls_ff <= 5'h00;
    end
    else
    begin
      ext_q_ff <= ext_clk;
      if (wr_rise)
        falls_ff <= 5'h00;
      else if (ext_q_ff && !ext_clk && falls_ff != 5'h1F)
        falls_ff <= falls_ff + 5'h01;
    end
  end

  // ******************************************************************
  // Assertions
  // ******************************************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_flag_up;
    ##1 done_n;
  endsequence

  flag_oe_select_a: assert property (done_oe == !cs_n)
    else $error("completion flag drive does not follow chip select");
  data_oe_read_a: assert property (dev_d_oe |-> !cs_n && !rd_n)
    else $error("data bus driven outside a selected read");
  write_clears_flag_a: assert property (wr_rise |-> s_flag_up)
    else $error("flag not released after a write");
  read_clears_flag_a: assert property (rd_fall && !done_n |-> s_flag_up)
    else $error("flag not released after a read");
  flag_holds_a: assert property (!done_n && !rd_fall && !wr_rise |=> !done_n)
    else $error("flag released without a read or write");
  conv_length_a: assert property ($fell(done_n) && clk_ext_ff |->
    falls_ff == (prev_acq_ff ? CONV_CYCLES : CONV_CYCLES + ACQ_INT_FALLS))
    else $error("conversion finished after a wrong count of clock falls");
  ext_acq_waits_a: assert property (acq_ff |-> done_n)
    else $error("conversion finished during an open acquisition");
  high_fill_a: assert property (dev_d_oe && $past(dev_d_oe) && high_byte_select
    && $stable(high_byte_select) |-> dev_d[7:4] == (uni_ff ? 4'h0 : {4{dev_d[3]}}))
    else $error("upper bus bits not filled correctly");
endmodule : sac_chk
`default_nettype wire

// [testbench/tb_sar_adc_acquisition_control.sv]
// Testbench joining host and converter ends through the parallel port.
`timescale 1ns/100ps
`default_nettype none
module tb_sar_adc_acquisition_control;
  // ******************************************************************
  // Stimulus, instances and clocks
  // ******************************************************************
  logic        mclk_i   = 1'b0;
  logic        nrst_i   = 1'b0;
  logic        wr_req   = 1'b0;
  logic        rd_req   = 1'b0;
  logic        ext_clk  = 1'b0;
  logic        cmp      = 1'b1;
  logic [7:0]  wr_byte  = 8'h00;
  logic [2:0]  ext_div  = 3'h0;
  logic        busy;
  logic        rd_valid;
  logic        done;
  logic        track;
  logic        ret;
  logic [11:0] rd_data;
  logic [11:0] dac;
  logic [2:0]  pos;
  logic [2:0]  neg;
  logic [1:0]  pmode;
  int          n_errors = 0;
  int          compares = 0;

  sac_if u_sac_if ();
  sac_dev u_sac_dev (.mclk_i(mclk_i), .nrst_i(nrst_i), .bus(u_sac_if), .cmp_i(cmp),
    .track_o(track), .pos_node_o(pos), .neg_node_o(neg), .neg_is_return_o(ret),
    .dac_code_o(dac), .power_mode_o(pmode));
  sac_host u_sac_host (.mclk_i(mclk_i), .nrst_i(nrst_i), .bus(u_sac_if), .wr_req_i(wr_req),
    .wr_byte_i(wr_byte), .rd_req_i(rd_req), .ext_clk_i(ext_clk), .busy_o(busy),
    .rd_valid_o(rd_valid), .rd_data_o(rd_data), .done_o(done));
  sac_chk u_sac_chk (.mclk_i(mclk_i), .nrst_i(nrst_i), .cs_n(u_sac_if.cs_n),
    .wr_n(u_sac_if.wr_n), .rd_n(u_sac_if.rd_n), .high_byte_select(u_sac_if.high_byte_select),
    .ext_clk(u_sac_if.ext_clk), .host_d(u_sac_if.host_d), .dev_d(u_sac_if.dev_d),
    .dev_d_oe(u_sac_if.dev_d_oe), .done_n(u_sac_if.done_n), .done_oe(u_sac_if.done_oe));

  // System clock at 100 MHz.
  initial
  begin
    forever #5 mclk_i = ~mclk_i;
  end

  // Conversion clock of sixteen system cycles, well inside the legal range.
  always @(posedge mclk_i)
  begin
    ext_div <= ext_div + 3'h1;
    if (ext_div == 3'h7)
      ext_clk <= ~ext_clk;
  end

  // ******************************************************************
  // Tasks
  // ******************************************************************
  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  // Sampling on the falling edge keeps clear of the design's own updates.
  task automatic await(input int which, input int lim);
    int k;
    k = 0;
    @(negedge mclk_i);
    while ((which == 0) ? (busy !== 1'b0) : (which == 1) ? (rd_valid !== 1'b1)
           : (done !== 1'b1))
    begin
      @(negedge mclk_i);
      k++;
      if (k >= lim)
      begin
        n_errors++;
        $display("unexpected at %0t: wait %0d ran out", $time, which);
        end_of_test();
      end
    end
  endtask : await

  task automatic wr(input logic [7:0] b);
    await(0, 50);
    @(posedge mclk_i);
    wr_byte <= b;
    wr_req  <= 1'b1;
    @(posedge mclk_i);
    wr_req  <= 1'b0;
    await(0, 50);
  endtask : wr

  task automatic rd(input logic [11:0] exp);
    await(0, 50);
    @(posedge mclk_i);
    rd_req <= 1'b1;
    @(posedge mclk_i);
    rd_req <= 1'b0;
    await(1, 100);
    chk(rd_data, exp);
    await(0, 50);
  endtask : rd

  // ******************************************************************
  // Tests
  // ******************************************************************
  initial
  begin
    repeat (6) @(posedge mclk_i);
    nrst_i <= 1'b1;
    // Every power code; single-ended unipolar channel five, full-scale input.
    for (int i = 0; i < 4; i++)
    begin
      wr({i[1:0], 6'h1D});
      chk(track, 1'b1);
      chk(pmode, i[1:0]);
      chk(pos, 3'h5);
      chk(ret, 1'b1);
      await(2, 2000);
      chk(track, 1'b0);
      chk(dac, 12'hFFF);
      rd(12'hFFF);
      chk(u_sac_if.done_n, 1'b1);
    end
    rd(12'hFFF);
    $display("test power codes finished");
    // Open acquisition on a pseudo-differential bipolar pair, closed by a second write.
    @(posedge mclk_i) cmp <= 1'b0;
    wr(8'hE2);
    chk(pos, 3'h2);
    chk(neg, 3'h3);
    chk(ret, 1'b0);
    repeat (400) @(posedge mclk_i);
    chk(track, 1'b1);
    chk(done, 1'b0);
    wr(8'hC2);
    chk(track, 1'b0);
    await(2, 2000);
    chk(dac, 12'h000);
    rd(12'h800);
    $display("test external acquisition finished");
    // A write in mid-conversion must throw the first conversion away.
    @(posedge mclk_i) cmp <= 1'b1;
    wr(8'hDD);
    repeat (150) @(posedge mclk_i);
    chk(track, 1'b0);
    wr(8'hD9);
    chk(track, 1'b1);
    chk(pos, 3'h1);
    await(2, 2000);
    rd(12'hFFF);
    $display("test abort finished");
    end_of_test();
  end
endmodule : tb_sar_adc_acquisition_control
`default_nettype wire
